// [logic/ccpt_consts.vh]
`ifndef CCPT_CONSTS_VH
`define CCPT_CONSTS_VH

// register offsets
`define CCPT_OFS_SETUP0 8'h3A
`define CCPT_OFS_CMD0 8'h3B
`define CCPT_OFS_RECOV0 8'h3C
`define CCPT_OFS_SETUP1 8'h3D
`define CCPT_OFS_CMD1 8'h3E
`define CCPT_OFS_RECOV1 8'h3F
`define CCPT_OFS_CLKOPT 8'h2F
`define CCPT_OFS_STATUS 8'h2E

// timing register fields: [7:6] prescale select, [5:0] multiplier value
`define CCPT_PRES_MSB 7
`define CCPT_PRES_LSB 6
`define CCPT_MULT_MSB 5
`define CCPT_MULT_LSB 0

// prescale values selected by the prescale field
`define CCPT_PRES_SEL0 4'h1
`define CCPT_PRES_SEL1 4'h2
`define CCPT_PRES_SEL2 4'h4
`define CCPT_PRES_SEL3 4'h8

// reset values
`define CCPT_RST_SETUP 8'h01
`define CCPT_RST_CMD 8'h06
`define CCPT_RST_RECOV 8'h03
`define CCPT_RST_CLKOPT 8'h00

// clock option bit: 0 = synthesized, 1 = bypass
`define CCPT_CLKOPT_BYPASS 0

// synthesizer ratio: internal frequency is NUM/DEN of the input clock
`define CCPT_SYNTH_NUM 7
`define CCPT_SYNTH_DEN 4

// timing in picoseconds
`define CCPT_CLK_SYS_PERIOD_PS 5000
`define CCPT_INPUT_CLOCK_PERIOD_PS 69840

// phase codes
`define CCPT_PH_IDLE 3'h0
`define CCPT_PH_ALIGN 3'h1
`define CCPT_PH_SETUP 3'h2
`define CCPT_PH_CMD 3'h3
`define CCPT_PH_RECOV 3'h4

`endif

// [logic/ccpt_timing.v]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "ccpt_consts.vh"

module ccpt_timing #(
    parameter integer CLK_SYS_PERIOD_PS = `CCPT_CLK_SYS_PERIOD_PS,
    parameter integer INPUT_CLOCK_PERIOD_PS = `CCPT_INPUT_CLOCK_PERIOD_PS
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire host_io_rd_n,
    input wire host_io_wr_n,
    output reg general_strobe_out,
    input wire card_cycle_req,
    input wire card_timer_set,
    output wire card_cycle_busy,
    output reg card_setup_phase,
    output reg card_cmd_phase,
    output reg card_recov_phase,
    output reg card_cycle_done,
    output wire internal_tick
);

    // fractional accumulator steps, in picoseconds scaled so both modes are exact
    localparam [31:0] SYNTH_STEP = CLK_SYS_PERIOD_PS * `CCPT_SYNTH_NUM;
    localparam [31:0] SYNTH_WRAP = INPUT_CLOCK_PERIOD_PS * `CCPT_SYNTH_DEN;
    localparam [31:0] BYP_STEP = CLK_SYS_PERIOD_PS;
    localparam [31:0] BYP_WRAP = INPUT_CLOCK_PERIOD_PS;

    reg [7:0] setup_reg [0:1];
    reg [7:0] cmd_reg [0:1];
    reg [7:0] recov_reg [0:1];
    reg [7:0] clkopt_reg;
    reg [31:0] acc_reg;
    reg tick_reg;
    reg [2:0] phase_reg;
    reg [2:0] phase_next;
    reg [9:0] count_reg;
    reg [9:0] count_next;
    reg set_reg;
    reg [2:0] rd_sync_reg;
    reg [2:0] wr_sync_reg;
    wire bypass;
    wire [31:0] step;
    wire [31:0] wrap;
    wire [31:0] acc_sum;

    // phase length in internal clocks from one timing register
    function [9:0] ccpt_phase_len;
        input [7:0] t;
        reg [3:0] pres;
        begin
            case (t[`CCPT_PRES_MSB:`CCPT_PRES_LSB])
                2'h0: pres = `CCPT_PRES_SEL0;
                2'h1: pres = `CCPT_PRES_SEL1;
                2'h2: pres = `CCPT_PRES_SEL2;
                default: pres = `CCPT_PRES_SEL3;
            endcase
            ccpt_phase_len = {6'h00, pres} * {4'h0, t[`CCPT_MULT_MSB:`CCPT_MULT_LSB]}
                + 10'h001;
        end
    endfunction

    // register file
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_set
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    setup_reg[gi] <= `CCPT_RST_SETUP;
                    cmd_reg[gi] <= `CCPT_RST_CMD;
                    recov_reg[gi] <= `CCPT_RST_RECOV;
                end else if (reg_wr) begin
                    if (reg_addr == (gi ? `CCPT_OFS_SETUP1 : `CCPT_OFS_SETUP0)) begin
                        setup_reg[gi] <= reg_wdata;
                    end else if (reg_addr == (gi ? `CCPT_OFS_CMD1 : `CCPT_OFS_CMD0)) begin
                        cmd_reg[gi] <= reg_wdata;
                    end else if (reg_addr == (gi ? `CCPT_OFS_RECOV1 : `CCPT_OFS_RECOV0)) begin
                        recov_reg[gi] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            clkopt_reg <= `CCPT_RST_CLKOPT;
        end else if (reg_wr && reg_addr == `CCPT_OFS_CLKOPT) begin
            clkopt_reg <= {7'h00, reg_wdata[`CCPT_CLKOPT_BYPASS]};
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `CCPT_OFS_SETUP0) begin
                reg_rdata <= setup_reg[0];
            end else if (reg_addr == `CCPT_OFS_CMD0) begin
                reg_rdata <= cmd_reg[0];
            end else if (reg_addr == `CCPT_OFS_RECOV0) begin
                reg_rdata <= recov_reg[0];
            end else if (reg_addr == `CCPT_OFS_SETUP1) begin
                reg_rdata <= setup_reg[1];
            end else if (reg_addr == `CCPT_OFS_CMD1) begin
                reg_rdata <= cmd_reg[1];
            end else if (reg_addr == `CCPT_OFS_RECOV1) begin
                reg_rdata <= recov_reg[1];
            end else if (reg_addr == `CCPT_OFS_CLKOPT) begin
                reg_rdata <= clkopt_reg;
            end else if (reg_addr == `CCPT_OFS_STATUS) begin
                reg_rdata <= {3'h0, general_strobe_out, set_reg, phase_reg};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // internal clock as a tick; the accumulator keeps the 7/4 ratio (1/1 in bypass) exact over time
    assign bypass = clkopt_reg[`CCPT_CLKOPT_BYPASS];
    assign step = bypass ? BYP_STEP : SYNTH_STEP;
    assign wrap = bypass ? BYP_WRAP : SYNTH_WRAP;
    assign acc_sum = acc_reg + step;
    assign internal_tick = tick_reg;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            acc_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `CCPT_OFS_CLKOPT) begin
            // restart on a mode write: a leftover synth phase would burst ticks in bypass
            acc_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= wrap) begin
            acc_reg <= acc_sum - wrap;
            tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // phase sequencer; a cycle waits for a tick so the first phase is never short
    always @* begin
        phase_next = phase_reg;
        count_next = count_reg;
        case (phase_reg)
            `CCPT_PH_IDLE: begin
                if (card_cycle_req) begin
                    phase_next = `CCPT_PH_ALIGN;
                end
            end
            `CCPT_PH_ALIGN: begin
                if (tick_reg) begin
                    phase_next = `CCPT_PH_SETUP;
                    count_next = ccpt_phase_len(setup_reg[set_reg]);
                end
            end
            `CCPT_PH_SETUP: begin
                if (tick_reg) begin
                    if (count_reg == 10'h001) begin
                        phase_next = `CCPT_PH_CMD;
                        count_next = ccpt_phase_len(cmd_reg[set_reg]);
                    end else begin
                        count_next = count_reg - 10'h001;
                    end
                end
            end
            `CCPT_PH_CMD: begin
                if (tick_reg) begin
                    if (count_reg == 10'h001) begin
                        phase_next = `CCPT_PH_RECOV;
                        count_next = ccpt_phase_len(recov_reg[set_reg]);
                    end else begin
                        count_next = count_reg - 10'h001;
                    end
                end
            end
            `CCPT_PH_RECOV: begin
                if (tick_reg) begin
                    if (count_reg == 10'h001) begin
                        phase_next = `CCPT_PH_IDLE;
                    end else begin
                        count_next = count_reg - 10'h001;
                    end
                end
            end
            default: begin
                phase_next = `CCPT_PH_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_reg <= `CCPT_PH_IDLE;
            count_reg <= 10'h000;
            set_reg <= 1'b0;
            card_setup_phase <= 1'b0;
            card_cmd_phase <= 1'b0;
            card_recov_phase <= 1'b0;
            card_cycle_done <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            count_reg <= count_next;
            // set is frozen for the whole cycle
            if (phase_reg == `CCPT_PH_IDLE && card_cycle_req) begin
                set_reg <= card_timer_set;
            end
            card_setup_phase <= (phase_next == `CCPT_PH_SETUP);
            card_cmd_phase <= (phase_next == `CCPT_PH_CMD);
            card_recov_phase <= (phase_next == `CCPT_PH_RECOV);
            card_cycle_done <= (phase_reg == `CCPT_PH_RECOV) && (phase_next == `CCPT_PH_IDLE);
        end
    end

    assign card_cycle_busy = (phase_reg != `CCPT_PH_IDLE);

    // host command pins are asynchronous: three stages, change taken when stages 2 and 3 agree
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_sync_reg <= 3'h7;
            wr_sync_reg <= 3'h7;
            general_strobe_out <= 1'b0;
        end else begin
            rd_sync_reg <= {rd_sync_reg[1:0], host_io_rd_n};
            wr_sync_reg <= {wr_sync_reg[1:0], host_io_wr_n};
            if ((rd_sync_reg[2:1] == 2'h0) || (wr_sync_reg[2:1] == 2'h0)) begin
                general_strobe_out <= 1'b1;
            end else if ((rd_sync_reg[2:1] == 2'h3) && (wr_sync_reg[2:1] == 2'h3)) begin
                general_strobe_out <= 1'b0;
            end
        end
    end

endmodule

// [testbench/ccpt_host_model.sv]
`timescale 1ns/1ps
module ccpt_host_model (
    input wire clk_sys,
    output reg host_io_rd_n,
    output reg host_io_wr_n
);
    initial begin
        host_io_rd_n = 1'b1;
        host_io_wr_n = 1'b1;
    end
    // released pins go back to the pulled-up idle level, never hold the last value
    task io_cmd(input bit is_wr, input integer len);
        begin
            @(posedge clk_sys);
            if (is_wr) begin
                host_io_wr_n <= 1'b0;
            end else begin
                host_io_rd_n <= 1'b0;
            end
            repeat (len) @(posedge clk_sys);
            host_io_rd_n <= 1'b1;
            host_io_wr_n <= 1'b1;
            // gap before the next command keeps the bus recovery time
            repeat (20) @(posedge clk_sys);
        end
    endtask
endmodule

// [testbench/ccpt_timing_assertions.sv]
`timescale 1ns/1ps
module ccpt_timing_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire host_io_rd_n,
    input wire host_io_wr_n,
    input wire general_strobe_out,
    input wire card_cycle_req,
    input wire card_cycle_busy,
    input wire card_setup_phase,
    input wire card_cmd_phase,
    input wire card_recov_phase,
    input wire card_cycle_done,
    input wire internal_tick
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_strobe_rise: assert property ((!host_io_rd_n || !host_io_wr_n) [*6] |-> general_strobe_out)
        else $error("strobe late");
    a_strobe_fall: assert property ((host_io_rd_n && host_io_wr_n) [*6] |-> !general_strobe_out)
        else $error("strobe stuck");
    a_phase_onehot: assert property ($onehot0({card_setup_phase, card_cmd_phase, card_recov_phase}))
        else $error("phases overlap");
    a_setup_then_cmd: assert property (card_setup_phase ##1 !card_setup_phase |-> card_cmd_phase)
        else $error("no command after setup");
    a_cmd_then_recov: assert property (card_cmd_phase ##1 !card_cmd_phase |-> card_recov_phase)
        else $error("no recovery after command");
    a_recov_then_done: assert property (card_recov_phase ##1 !card_recov_phase |-> ##[0:1] card_cycle_done)
        else $error("no done pulse");
    a_setup_on_tick: assert property ($rose(card_setup_phase) |-> $past(internal_tick))
        else $error("setup off tick");
    a_cmd_on_tick: assert property ($rose(card_cmd_phase) |-> $past(internal_tick))
        else $error("command off tick");
    a_tick_gap: assert property (internal_tick |=> !internal_tick [*6])
        else $error("ticks too close");
    a_busy_on_req: assert property (card_cycle_req && !card_cycle_busy |=> card_cycle_busy)
        else $error("request not taken");
    cover property (card_recov_phase ##1 card_cycle_done);
    cover property (card_cycle_busy && card_cycle_req);
    cover property ($rose(general_strobe_out));
endmodule
bind ccpt_timing ccpt_timing_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_io_rd_n(host_io_rd_n), .host_io_wr_n(host_io_wr_n),
    .general_strobe_out(general_strobe_out), .card_cycle_req(card_cycle_req),
    .card_cycle_busy(card_cycle_busy), .card_setup_phase(card_setup_phase),
    .card_cmd_phase(card_cmd_phase), .card_recov_phase(card_recov_phase),
    .card_cycle_done(card_cycle_done), .internal_tick(internal_tick));

// [testbench/ccpt_timing_tb.sv]
`timescale 1ns/1ps
`include "ccpt_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module ccpt_timing_tb;
    reg clk_sys, rst_n, reg_wr, reg_rd, card_cycle_req, card_timer_set;
    reg [7:0] reg_addr, reg_wdata;
    wire [7:0] reg_rdata;
    wire host_io_rd_n, host_io_wr_n, general_strobe_out, card_cycle_busy, internal_tick;
    wire card_setup_phase, card_cmd_phase, card_recov_phase, card_cycle_done;
    wire [2:0] ph = {card_recov_phase, card_cmd_phase, card_setup_phase};
    integer n_errors = 0, n_compared = 0, seed = 50217, i, k;
    reg rd_v = 1'b0;
    reg [2:0] ph_d = 3'h0;
    reg [12:0] cnt = 13'h0;
    reg [7:0] nt;
    reg [7:0] regs [0:5];
    reg [31:0] r;
    logic [15:0] e;
    logic [15:0] rd_q[$], len_q[$];
    // exact 8 and 14 cycle internal periods keep tick counts free of jitter
    ccpt_timing #(.INPUT_CLOCK_PERIOD_PS(70000)) u_ccpt_timing (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .host_io_rd_n(host_io_rd_n), .host_io_wr_n(host_io_wr_n),
        .general_strobe_out(general_strobe_out), .card_cycle_req(card_cycle_req),
        .card_timer_set(card_timer_set), .card_cycle_busy(card_cycle_busy),
        .card_setup_phase(card_setup_phase), .card_cmd_phase(card_cmd_phase),
        .card_recov_phase(card_recov_phase), .card_cycle_done(card_cycle_done),
        .internal_tick(internal_tick));
    ccpt_host_model u_ccpt_host_model (.clk_sys(clk_sys), .host_io_rd_n(host_io_rd_n),
        .host_io_wr_n(host_io_wr_n));
    function [12:0] plen(input [7:0] v);
        plen = (13'h1 << v[7:6]) * v[5:0] + 13'h1;
    endfunction
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] x);
        rd_q.push_back({8'h00, x});
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task run_cycle(input bit s, input [7:0] a, input [7:0] b, input [7:0] c);
        len_q.push_back({3'h1, plen(a)});
        len_q.push_back({3'h2, plen(b)});
        len_q.push_back({3'h4, plen(c)});
        @(posedge clk_sys);
        card_cycle_req <= 1'b1;
        card_timer_set <= s;
        @(posedge clk_sys);
        card_cycle_req <= 1'b0;
        card_timer_set <= ~s;
        repeat (3) @(posedge clk_sys);
        // a request while busy must leave no trace in the phase sequence
        card_cycle_req <= 1'b1;
        @(posedge clk_sys);
        card_cycle_req <= 1'b0;
        k = 0;
        while (card_cycle_busy !== 1'b0 && k < 20000) begin
            @(posedge clk_sys);
            k++;
        end
        `CHK("cycle_end", 1'b0, card_cycle_busy)
    endtask
    task tick_count(input [7:0] x);
        k = 0;
        while (internal_tick !== 1'b1 && k < 100) begin
            @(posedge clk_sys);
            k++;
        end
        `CHK("tick_seen", 1'b1, internal_tick)
        nt = 8'h00;
        repeat (560) begin
            @(posedge clk_sys);
            if (internal_tick === 1'b1) nt++;
        end
        `CHK("tick_count", x, nt)
    endtask
    task tally_and_finish;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (rd_v) begin
            e = rd_q.pop_front();
            `CHK("reg_rdata", e[7:0], reg_rdata)
        end
        rd_v = reg_rd;
        if (ph_d != 3'h0 && ph != ph_d) begin
            e = len_q.pop_front();
            `CHK("phase_ticks", e, {ph_d, cnt})
            if (ph_d == 3'h4) `CHK("cycle_done", 1'b1, card_cycle_done)
            cnt = 13'h0;
        end
        if (ph != 3'h0 && internal_tick === 1'b1) cnt++;
        ph_d = ph;
    end
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #500000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, card_cycle_req, card_timer_set} = 5'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++) rd(8'h3A + i, (i % 3 == 0) ? 8'h01 : (i % 3 == 1) ? 8'h06 : 8'h03);
        rd(`CCPT_OFS_CLKOPT, 8'h00);
        wr(8'h10, 8'hA5);
        rd(8'h10, 8'h00);
        run_cycle(1'b0, 8'h01, 8'h06, 8'h03);
        for (i = 0; i < 4; i++) begin
            for (k = 0; k < 6; k++) begin
                r = $random(seed);
                regs[k] = (i == 1 && k == 3) ? 8'h40 : {i[1:0], r[5:0]};
                wr(8'h3A + k, regs[k]);
                rd(8'h3A + k, regs[k]);
            end
            run_cycle(i[0], regs[3 * i[0]], regs[3 * i[0] + 1], regs[3 * i[0] + 2]);
        end
        // idle, strobe low, set 1 still latched from the last cycle
        rd(`CCPT_OFS_STATUS, 8'h08);
        tick_count(8'h46);
        wr(`CCPT_OFS_CLKOPT, 8'h01);
        tick_count(8'h28);
        wr(`CCPT_OFS_CLKOPT, 8'h00);
        tick_count(8'h46);
        for (i = 0; i < 2; i++) begin
            fork
                u_ccpt_host_model.io_cmd(i[0], 30);
                begin
                    repeat (12) @(posedge clk_sys);
                    `CHK("strobe_on", 1'b1, general_strobe_out)
                end
            join
            `CHK("strobe_off", 1'b0, general_strobe_out)
        end
        tally_and_finish;
    end
endmodule
